// [cmd_frame_consts.svh]
`ifndef CMD_FRAME_CONSTS_SVH
`define CMD_FRAME_CONSTS_SVH
`define FRAME_LEN 4'd9
`define PAYLOAD_LEN 4'd7
`define LAST_SUM_IDX 4'd7
`define STATUS_OK 8'h64
`define STATUS_BAD_SUM 8'h01
`define STATUS_BAD_CMD 8'h02
`define CLK_HZ 40000000
`define GAP_TIMEOUT_US 1000
`define GAP_TIMEOUT_CYC ((`GAP_TIMEOUT_US * (`CLK_HZ / 1000000)))
`endif

// [cmd_frame_pkg.sv]
package cmd_frame_pkg;
   typedef enum logic [1:0] {
      ST_RX,
      ST_EXEC,
      ST_TX
   } state_t;
endpackage

// [binary_command_frame_handler.sv]
`timescale 1ns/1ps
`include "cmd_frame_consts.svh"
module binary_command_frame_handler
   import cmd_frame_pkg::*;
#(
   parameter int GAP_TIMEOUT_CYCLES = `GAP_TIMEOUT_CYC
) (
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic CAN_MODE_IN,
   input wire logic [7:0] MODULE_ADDR_IN,
   input wire logic [7:0] REPLY_ADDR_IN,
   input wire logic [7:0] RX_DATA_IN,
   input wire logic RX_VALID_IN,
   output logic [7:0] TX_DATA_OUT,
   output logic TX_VALID_OUT,
   input wire logic TX_READY_IN,
   output logic TX_ENABLE_OUT,
   output logic CMD_VALID_OUT,
   output logic [7:0] CMD_NUM_OUT,
   output logic [7:0] CMD_TYPE_OUT,
   output logic [7:0] CMD_BANK_OUT,
   output logic [31:0] CMD_VALUE_OUT,
   input wire logic EXEC_DONE_IN,
   input wire logic EXEC_INVALID_IN,
   input wire logic [31:0] EXEC_VALUE_IN
);
   state_t state_reg, state_next;
   logic [3:0] idx_reg, idx_next;
   logic [7:0] sum_reg, sum_next;
   logic [7:0] buf_reg [0:8];
   logic [7:0] buf_next [0:8];
   logic [31:0] gap_reg, gap_next;
   logic cmd_valid_reg, cmd_valid_next;
   logic tx_valid_reg, tx_valid_next;
   logic [7:0] tx_data_reg, tx_data_next;
   logic [7:0] stat_reg, stat_next;
   logic [3:0] first_idx, last_idx, tx_first_idx, rx_idx;

   // reply byte i in byte-link layout; CAN uses only the payload part
   function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic [7:0] st, input logic [7:0] cmd,
                                             input logic [31:0] v, input logic [7:0] cs);
      case (i)
         4'd0: reply_byte = REPLY_ADDR_IN;
         4'd1: reply_byte = MODULE_ADDR_IN;
         4'd2: reply_byte = st;
         4'd3: reply_byte = cmd;
         4'd4: reply_byte = v[31:24];
         4'd5: reply_byte = v[23:16];
         4'd6: reply_byte = v[15:8];
         4'd7: reply_byte = v[7:0];
         default: reply_byte = cs;
      endcase
   endfunction

   // value field occupies slots 4..7, high byte first
   function automatic logic [31:0] value_field(input logic [7:0] b [0:8]);
      value_field = {b[4], b[5], b[6], b[7]};
   endfunction

   // byte-link frames use positions 0..8, CAN frames 1..7
   always_comb begin
      first_idx = CAN_MODE_IN ? 4'd1 : 4'd0;
      last_idx = CAN_MODE_IN ? `LAST_SUM_IDX : (`FRAME_LEN - 4'd1);
      // CAN replies drop both address slots and the checksum
      tx_first_idx = CAN_MODE_IN ? 4'd2 : 4'd0;
      // after reset the index may sit below a CAN frame's first slot
      rx_idx = (idx_reg < first_idx) ? first_idx : idx_reg;
   end

   logic [31:0] rx_value;
   always_comb begin
      rx_value = value_field(buf_reg);
   end

   // status kept apart so the type slot survives for the executor
   always_comb begin
      stat_next = stat_reg;
      if (state_reg == ST_RX && RX_VALID_IN && rx_idx == last_idx) begin
         // a checksum failure is final; the executor is never asked
         if (!CAN_MODE_IN && RX_DATA_IN != sum_reg) begin
            stat_next = `STATUS_BAD_SUM;
         end else begin
            stat_next = `STATUS_OK;
         end
      end else if (state_reg == ST_EXEC && stat_reg == `STATUS_OK && EXEC_DONE_IN) begin
         stat_next = EXEC_INVALID_IN ? `STATUS_BAD_CMD : `STATUS_OK;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         stat_reg <= 8'h00;
      end else begin
         stat_reg <= stat_next;
      end
   end

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      sum_next = sum_reg;
      gap_next = gap_reg;
      cmd_valid_next = 1'b0;
      tx_valid_next = tx_valid_reg;
      tx_data_next = tx_data_reg;
      for (int k = 0; k < 9; k++) begin
         buf_next[k] = buf_reg[k];
      end
      case (state_reg)
         ST_RX: begin
            if (RX_VALID_IN) begin
               gap_next = 32'h0;
               buf_next[rx_idx] = RX_DATA_IN;
               if (rx_idx == last_idx) begin
                  idx_next = first_idx;
                  sum_next = 8'h00;
                  state_next = ST_EXEC;
                  // only a frame that passes the check reaches the executor
                  if (CAN_MODE_IN || RX_DATA_IN == sum_reg) begin
                     cmd_valid_next = 1'b1;
                  end
               end else begin
                  idx_next = rx_idx + 4'd1;
                  sum_next = sum_reg + RX_DATA_IN;
               end
            end else if (idx_reg > first_idx) begin
               if (gap_reg >= GAP_TIMEOUT_CYCLES - 1) begin
                  idx_next = first_idx;
                  sum_next = 8'h00;
                  gap_next = 32'h0;
               end else begin
                  gap_next = gap_reg + 32'h1;
               end
            end else begin
               idx_next = first_idx;
            end
         end
         ST_EXEC: begin
            // a checksum failure answers without waiting on the executor
            if (stat_reg != `STATUS_OK || EXEC_DONE_IN) begin
               if (stat_reg == `STATUS_OK) begin
                  buf_next[4] = EXEC_VALUE_IN[31:24];
                  buf_next[5] = EXEC_VALUE_IN[23:16];
                  buf_next[6] = EXEC_VALUE_IN[15:8];
                  buf_next[7] = EXEC_VALUE_IN[7:0];
               end
               idx_next = tx_first_idx;
               sum_next = 8'h00;
               state_next = ST_TX;
            end
         end
         ST_TX: begin
            if (!tx_valid_reg || TX_READY_IN) begin
               if (tx_valid_reg && idx_reg == last_idx + 4'd1) begin
                  tx_valid_next = 1'b0;
                  idx_next = first_idx;
                  sum_next = 8'h00;
                  state_next = ST_RX;
               end else if (idx_reg <= last_idx) begin
                  // the checksum slot sees the sum of the bytes already loaded
                  tx_data_next = reply_byte(idx_reg, stat_reg, buf_reg[1], value_field(buf_reg), sum_reg);
                  sum_next = sum_reg + tx_data_next;
                  tx_valid_next = 1'b1;
                  idx_next = idx_reg + 4'd1;
               end
            end
         end
         default: begin
            state_next = ST_RX;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_reg <= ST_RX;
         idx_reg <= 4'd0;
         sum_reg <= 8'h00;
         gap_reg <= 32'h0;
         cmd_valid_reg <= 1'b0;
         tx_valid_reg <= 1'b0;
         tx_data_reg <= 8'h00;
         for (int k = 0; k < 9; k++) begin
            buf_reg[k] <= 8'h00;
         end
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         sum_reg <= sum_next;
         gap_reg <= gap_next;
         cmd_valid_reg <= cmd_valid_next;
         tx_valid_reg <= tx_valid_next;
         tx_data_reg <= tx_data_next;
         for (int k = 0; k < 9; k++) begin
            buf_reg[k] <= buf_next[k];
         end
      end
   end

   // reset index follows mode only in idle receive; mode must be static otherwise
   assign CMD_VALID_OUT = cmd_valid_reg;
   assign CMD_NUM_OUT = buf_reg[1];
   assign CMD_TYPE_OUT = buf_reg[2];
   assign CMD_BANK_OUT = buf_reg[3];
   assign CMD_VALUE_OUT = rx_value;
   assign TX_DATA_OUT = tx_data_reg;
   assign TX_VALID_OUT = tx_valid_reg;
   assign TX_ENABLE_OUT = (state_reg == ST_TX);
endmodule

// [frame_checker.sv]
`timescale 1ns/1ps
module frame_checker(
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic CAN_MODE_IN,
   input wire logic [7:0] MODULE_ADDR_IN,
   input wire logic [7:0] REPLY_ADDR_IN,
   input wire logic [7:0] TX_DATA_OUT,
   input wire logic TX_VALID_OUT,
   input wire logic TX_READY_IN,
   input wire logic TX_ENABLE_OUT,
   input wire logic CMD_VALID_OUT
);
   logic [3:0] n_reg;
   logic [7:0] s_reg;
   wire logic take = TX_VALID_OUT && TX_READY_IN;
   wire logic [3:0] last = CAN_MODE_IN ? 4'h5 : 4'h8;
   // cleared whenever the transceiver is released, so no reset needed
   always_ff @(posedge MCLK_IN) begin
      n_reg <= TX_ENABLE_OUT ? n_reg + 4'(take) : 4'h0;
      s_reg <= TX_ENABLE_OUT ? s_reg + (take ? TX_DATA_OUT : 8'h00) : 8'h00;
   end
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   tx_in_window_a: assert property (TX_VALID_OUT |-> TX_ENABLE_OUT) else $error("tx off");
   tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
      else $error("tx drop");
   reply_addr_a: assert property (TX_VALID_OUT && n_reg == 0 && !CAN_MODE_IN |-> TX_DATA_OUT == REPLY_ADDR_IN)
      else $error("reply addr");
   own_addr_a: assert property (TX_VALID_OUT && n_reg == 1 && !CAN_MODE_IN |-> TX_DATA_OUT == MODULE_ADDR_IN)
      else $error("module addr");
   status_code_a: assert property (TX_VALID_OUT && n_reg == (CAN_MODE_IN ? 0 : 2)
      |-> TX_DATA_OUT inside {8'h64, 8'h01, 8'h02}) else $error("status");
   reply_sum_a: assert property (TX_VALID_OUT && n_reg == 8 && !CAN_MODE_IN |-> TX_DATA_OUT == s_reg)
      else $error("sum");
   reply_len_a: assert property (TX_VALID_OUT |-> n_reg <= last) else $error("too long");
   reply_end_a: assert property (take && n_reg == last |=> !TX_VALID_OUT ##[0:1] !TX_ENABLE_OUT)
      else $error("no release");
   quiet_cmd_a: assert property (CMD_VALID_OUT |-> !TX_ENABLE_OUT ##1 !CMD_VALID_OUT)
      else $error("cmd pulse");
   cover property (take && n_reg == last);
   cover property (CMD_VALID_OUT);
   cover property (TX_VALID_OUT && !TX_READY_IN);
endmodule
bind binary_command_frame_handler frame_checker frame_checker_inst(.MCLK_IN, .RESETN_IN, .CAN_MODE_IN,
   .MODULE_ADDR_IN, .REPLY_ADDR_IN, .TX_DATA_OUT, .TX_VALID_OUT, .TX_READY_IN, .TX_ENABLE_OUT, .CMD_VALID_OUT);

// [reply_sink.sv]
`timescale 1ns/1ps
module reply_sink(
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   output logic ready_out
);
   logic [7:0] got[$];
   logic phase_reg = 1'b0;
   assign ready_out = !slow_in || phase_reg;
   always @(posedge clk_in) begin
      phase_reg <= ~phase_reg;
      if (valid_in && ready_out) got.push_back(data_in);
   end
endmodule

// [binary_command_frame_handler_bench.sv]
`timescale 1ns/1ps
module binary_command_frame_handler_bench;
   logic clk = 0, rst_n = 0, can = 0, rxv = 0, done = 0, inv = 0, slow = 0, rdy, txv, txen, cmdv;
   logic [7:0] rxd = 0, txd, num, typ, bank;
   logic [31:0] xval = 0, cval;
   int failures = 0, checked = 0;
   logic [50:0] rows [4] = '{{8'h01, 32'h12345678, 3'b000, 8'h64}, {8'h06, 32'h80000001, 3'b101, 8'h01},
      {8'hff, 32'h00000000, 3'b011, 8'h02}, {8'h05, 32'hffffffff, 3'b000, 8'h64}};
   always #12.5 clk = ~clk;
   binary_command_frame_handler #(.GAP_TIMEOUT_CYCLES(20)) binary_command_frame_handler_inst(.MCLK_IN(clk),
      .RESETN_IN(rst_n), .CAN_MODE_IN(can), .MODULE_ADDR_IN(8'h05), .REPLY_ADDR_IN(8'h02), .RX_DATA_IN(rxd),
      .RX_VALID_IN(rxv), .TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .TX_READY_IN(rdy), .TX_ENABLE_OUT(txen),
      .CMD_VALID_OUT(cmdv), .CMD_NUM_OUT(num), .CMD_TYPE_OUT(typ), .CMD_BANK_OUT(bank), .CMD_VALUE_OUT(cval),
      .EXEC_DONE_IN(done), .EXEC_INVALID_IN(inv), .EXEC_VALUE_IN(xval));
   reply_sink reply_sink_inst(.clk_in(clk), .slow_in(slow), .data_in(txd), .valid_in(txv), .ready_out(rdy));
   task automatic conclude();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic await(ref logic sig, input logic lvl);
      for (int i = 0; sig !== lvl; i++) begin
         if (i == 200) begin
            failures++;
            conclude();
         end
         @(negedge clk);
      end
   endtask
   function automatic logic [7:0] sum(input logic [7:0] b[$]);
      sum = 0;
      foreach (b[i]) sum += b[i];
   endfunction
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(negedge clk);
         rxd = b[i];
         rxv = 1;
      end
      @(negedge clk);
      rxv = 0;
   endtask
   // row: cmd, value, bad sum, invalid, slow host, status
   task automatic run(input logic [50:0] r);
      logic [7:0] p[$];
      logic [7:0] q[$];
      logic [31:0] v;
      logic [31:0] rv;
      v = r[42:11];
      rv = r[10] ? v : ~v;
      slow = r[8];
      p = {r[50:43], 8'h03, 8'h01, v[31:24], v[23:16], v[15:8], v[7:0]};
      q = {r[7:0], r[50:43], rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
      reply_sink_inst.got.delete();
      if (can) send(p);
      else send({8'h05, p, sum(p) + 8'h05 + 8'(r[10])});
      if (!can) q = {8'h02, 8'h05, q, sum(q) + 8'h07};
      if (r[10]) cmp(cmdv, 0);
      if (!r[10]) begin
         await(cmdv, 1);
         cmp({num, typ, bank, cval}, {p[0], 8'h03, 8'h01, v});
         done = 1;
         inv = r[9];
         xval = rv;
         @(negedge clk);
         done = 0;
      end
      await(txen, 1);
      await(txen, 0);
      cmp(reply_sink_inst.got.size(), q.size());
      foreach (q[i]) cmp(reply_sink_inst.got[i], q[i]);
      $display("test cmd %h done", p[0]);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      cmp({txv, txen, cmdv}, 0);
      $display("test reset done");
      rst_n = 1;
      foreach (rows[k]) run(rows[k]);
      send({8'h05, 8'h01, 8'h03, 8'h01});
      repeat (25) @(negedge clk);
      cmp(txen, 0);
      run(rows[0]);
      rst_n = 0;
      can = 1;
      @(negedge clk);
      rst_n = 1;
      run(rows[3]);
      conclude();
   end
endmodule
